// File: src/psp_pkg.sv
// Shared constants and types for the power stage protection controller
package psp_pkg;
  // Synchroniser depth
  localparam int SYNC_STAGES = 2;
  // Register offsets (byte addresses)
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_ST = 8'h08;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_CL = 8'h10;
  // Status bit positions
  localparam int ST_LATCHED = 0;
  localparam int ST_OC_HS   = 1;
  localparam int ST_OC_LS   = 2;
  localparam int ST_UV      = 3;
  localparam int ST_OTE     = 4;
  localparam int ST_OTW     = 5;
  localparam int ST_HIZ     = 6;
  localparam int ST_RST     = 7;
  // Event bits: 0 error latched, 1 warning raised, 2 reset released
  localparam int EV_ERR  = 0;
  localparam int EV_WARN = 1;
  localparam int EV_RUN  = 2;
  localparam int EV_W    = 3;
  // Reset values
  localparam logic [EV_W-1:0] IRQ_EN_RST = 3'h0;
  localparam logic            CTRL_RST   = 1'b0;
  // Stage control states
  typedef enum logic [2:0] {
    PSP_HIZ   = 3'b001,
    PSP_RUN   = 3'b010,
    PSP_FAULT = 3'b100
  } psp_state_t;
endpackage : psp_pkg

// File: src/psp_sync.sv
// Two-flop synchroniser bank for asynchronous detector and reset levels
`timescale 1ns/1ps
module psp_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,  // System clock
  input  wire logic             rst_i,  // Synchronous reset
  input  wire logic [WIDTH-1:0] d_i,    // Asynchronous levels
  output logic      [WIDTH-1:0] q_o     // Synchronised levels
);
  logic [WIDTH-1:0] stage1;

  // First flop feeds only the second flop to keep metastability contained
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stage1 <= '0;
      q_o    <= '0;
    end else begin
      stage1 <= d_i;
      q_o    <= stage1;
    end
  end
endmodule : psp_sync

// File: src/psp_ctrl.sv
// Protection, reset sequencing and status reporting for the power stage
//
// Summary of operation
// - Reset low: all transistors off, bridges high-impedance.
// - Fault indicator low on error while reset high.
// - Fault indicator released high whenever reset low.
// - Warning output low above 125 C junction.
// - Output pair encodes error, warning or normal.
// - Covered error latches, stage goes high-impedance.
// - Latch clears on reset fall, runs after rise.
// - Overcurrent detected separately high and low side.
// - One shared detector raises the temperature warning.
// - Undervoltage is an error during power up/down.
// - Overtemperature error distinct at 150 C.
//
// Implementation choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
module psp_ctrl #(
  parameter int CHANNELS = 2
) (
  input  wire logic                clk_i,        // 100 MHz clock
  input  wire logic                rst_i,        // Synchronous reset, active high
  input  wire logic                reset_n_i,    // Device reset pin, active low
  input  wire logic [CHANNELS-1:0] pwm_positive_input_i, // PWM from modulator
  input  wire logic [CHANNELS-1:0] oc_hs_i,      // High-side overcurrent detectors
  input  wire logic [CHANNELS-1:0] oc_ls_i,      // Low-side overcurrent detectors
  input  wire logic                undervoltage_fault_i, // Gate supply too low
  input  wire logic                overtemp_warn_i,      // Junction above 125 C
  input  wire logic                overtemp_error_i,     // Junction above 150 C
  output logic [CHANNELS-1:0]      hs_on_o,      // High-side gate enable
  output logic [CHANNELS-1:0]      ls_on_o,      // Low-side gate enable
  output logic                     hiz_o,        // Output stage high-impedance
  output logic                     fault_indicator_n_o,  // Open-drain data, always 0
  output logic                     fault_indicator_n_oe_o, // High while pulling low
  output logic                     temp_warning_n_o,     // Open-drain data, always 0
  output logic                     temp_warning_n_oe_o,  // High while pulling low
  input  wire logic [7:0]          wb_adr_i,     // Wishbone address
  input  wire logic [31:0]         wb_dat_i,     // Wishbone write data
  input  wire logic [3:0]          wb_sel_i,     // Wishbone byte selects
  input  wire logic                wb_we_i,      // Wishbone write enable
  input  wire logic                wb_cyc_i,     // Wishbone cycle
  input  wire logic                wb_stb_i,     // Wishbone strobe
  output logic [31:0]              wb_dat_o,     // Wishbone read data
  output logic                     wb_ack_o,     // Wishbone acknowledge
  output logic                     irq_o         // Level interrupt
);
  localparam int SW = 2 * CHANNELS + 4;

  // Synchronised levels
  logic [SW-1:0] raw_in;
  logic [SW-1:0] sync_q;
  logic [CHANNELS-1:0] oc_hs_s;
  logic [CHANNELS-1:0] oc_ls_s;
  logic          uv_s;
  logic          otw_s;
  logic          ote_s;
  logic          rstn_s;
  logic          rstn_d;

  // State and registers
  psp_pkg::psp_state_t state;
  psp_pkg::psp_state_t next_state;
  logic                err_latch;
  logic                err_oc_hs;
  logic                err_oc_ls;
  logic                err_uv;
  logic                err_ote;
  logic                mute;
  logic [psp_pkg::EV_W-1:0] irq_st;
  logic [psp_pkg::EV_W-1:0] irq_en;
  logic                otw_d;

  // Reset and detectors pass through the synchroniser first
  assign raw_in = {reset_n_i, overtemp_error_i, overtemp_warn_i,
                   undervoltage_fault_i, oc_ls_i, oc_hs_i};

  psp_sync #(
    .WIDTH (SW)
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (raw_in),
    .q_o   (sync_q)
  );

  assign oc_hs_s = sync_q[CHANNELS-1:0];
  assign oc_ls_s = sync_q[2*CHANNELS-1:CHANNELS];
  assign uv_s    = sync_q[2*CHANNELS];
  assign otw_s   = sync_q[2*CHANNELS+1];
  assign ote_s   = sync_q[2*CHANNELS+2];
  assign rstn_s  = sync_q[2*CHANNELS+3];

  // Error decode: each side and each channel counts alone
  wire any_oc_hs = |oc_hs_s;
  wire any_oc_ls = |oc_ls_s;
  wire any_err   = any_oc_hs | any_oc_ls | uv_s | ote_s;
  wire rst_fall  = rstn_d & ~rstn_s;
  wire rst_rise  = ~rstn_d & rstn_s;

  // Bus decode
  wire wb_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr     = wb_req & wb_we_i & wb_sel_i[0];
  wire wr_ctrl   = wb_wr & (wb_adr_i == psp_pkg::ADDR_CTRL);
  wire wr_en     = wb_wr & (wb_adr_i == psp_pkg::ADDR_IRQ_EN);
  wire wr_clr    = wb_wr & (wb_adr_i == psp_pkg::ADDR_IRQ_CL);

  // Events for the interrupt status
  wire [psp_pkg::EV_W-1:0] ev;
  assign ev[psp_pkg::EV_ERR]  = (state == psp_pkg::PSP_RUN) & any_err;
  assign ev[psp_pkg::EV_WARN] = otw_s & ~otw_d;
  assign ev[psp_pkg::EV_RUN]  = rst_rise;

  // Stage control: reset low wins over everything, an error stops RUN
  always_comb begin
    next_state = state;
    case (state)
      psp_pkg::PSP_HIZ: begin
        if (rstn_s && !err_latch && !any_err)
          next_state = psp_pkg::PSP_RUN;
      end
      psp_pkg::PSP_RUN: begin
        if (!rstn_s)
          next_state = psp_pkg::PSP_HIZ;
        else if (any_err)
          next_state = psp_pkg::PSP_FAULT;
      end
      psp_pkg::PSP_FAULT: begin
        if (!rstn_s)
          next_state = psp_pkg::PSP_HIZ;
      end
      default: next_state = psp_pkg::PSP_HIZ;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i)
      state <= psp_pkg::PSP_HIZ;
    else
      state <= next_state;
  end

  // Error latch records the cause; cleared only by rst_i or on the reset fall
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_latch <= 1'b0;
      err_oc_hs <= 1'b0;
      err_oc_ls <= 1'b0;
      err_uv    <= 1'b0;
      err_ote   <= 1'b0;
    end else if (rst_fall) begin
      err_latch <= 1'b0;
      err_oc_hs <= 1'b0;
      err_oc_ls <= 1'b0;
      err_uv    <= 1'b0;
      err_ote   <= 1'b0;
    end else if (rstn_s && any_err) begin
      err_latch <= 1'b1;
      err_oc_hs <= err_oc_hs | any_oc_hs;
      err_oc_ls <= err_oc_ls | any_oc_ls;
      err_uv    <= err_uv | uv_s;
      err_ote   <= err_ote | ote_s;
    end
  end

  // Edge history and software mute
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rstn_d <= 1'b0;
      otw_d  <= 1'b0;
      mute   <= psp_pkg::CTRL_RST;
    end else begin
      rstn_d <= rstn_s;
      otw_d  <= otw_s;
      if (wr_ctrl)
        mute <= wb_dat_i[0];
    end
  end

  // Gate drive follows PWM only in RUN; latch and mute force Hi-Z
  wire run_ok = (next_state == psp_pkg::PSP_RUN) & ~mute;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hs_on_o <= '0;
      ls_on_o <= '0;
      hiz_o   <= 1'b1;
    end else begin
      hs_on_o <= run_ok ? pwm_positive_input_i : '0;
      ls_on_o <= run_ok ? ~pwm_positive_input_i : '0;
      hiz_o   <= ~run_ok;
    end
  end

  // Reporting pins: fault only while reset high; warning follows sensor
  wire fault_pull = rstn_s & (err_latch | any_err) & ~rst_fall;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_indicator_n_o    <= 1'b0;
      fault_indicator_n_oe_o <= 1'b0;
      temp_warning_n_o       <= 1'b0;
      temp_warning_n_oe_o    <= 1'b0;
    end else begin
      fault_indicator_n_o    <= 1'b0;
      fault_indicator_n_oe_o <= fault_pull;
      temp_warning_n_o       <= 1'b0;
      temp_warning_n_oe_o    <= otw_s | ote_s;
    end
  end

  // Interrupt status: set wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_st <= '0;
      irq_en <= psp_pkg::IRQ_EN_RST;
      irq_o  <= 1'b0;
    end else begin
      irq_st <= (irq_st & ~(wr_clr ? wb_dat_i[psp_pkg::EV_W-1:0] : '0)) | ev;
      if (wr_en)
        irq_en <= wb_dat_i[psp_pkg::EV_W-1:0];
      irq_o  <= |(irq_st & irq_en);
    end
  end

  // Status word shows live state and latched causes
  wire [7:0] status_w = {rstn_s, hiz_o, otw_s, err_ote, err_uv,
                         err_oc_ls, err_oc_hs, err_latch};

  // Read mux; unmapped and write-only addresses read zero
  wire [31:0] rd_mux =
    (wb_adr_i == psp_pkg::ADDR_CTRL)   ? {31'h0, mute} :
    (wb_adr_i == psp_pkg::ADDR_STATUS) ? {24'h0, status_w} :
    (wb_adr_i == psp_pkg::ADDR_IRQ_ST) ? {29'h0, irq_st} :
    (wb_adr_i == psp_pkg::ADDR_IRQ_EN) ? {29'h0, irq_en} : 32'h0;

  // Single-wait-state slave: ack one cycle after strobe, one cycle wide
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_mux : 32'h0;
    end
  end

  // Reset low for two cycles forces Hi-Z
  hiz_on_reset_a : assert property (@(posedge clk_i) disable iff (rst_i)
    !rstn_s [*2] |=> hiz_o && hs_on_o == '0 && ls_on_o == '0)
    else $error("stage not Hi-Z under reset");

  // Fault pin released while reset low
  fault_release_a : assert property (@(posedge clk_i) disable iff (rst_i)
    !rstn_s |=> !fault_indicator_n_oe_o)
    else $error("fault pin pulled during reset");

  // Error with reset high pulls the fault pin next cycle
  fault_pull_a : assert property (@(posedge clk_i) disable iff (rst_i)
    rstn_s && any_err && !rst_fall |=> fault_indicator_n_oe_o)
    else $error("fault pin not pulled on error");

  // Warning pin tracks the synchronised sensor
  warn_track_a : assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 temp_warning_n_oe_o == $past(otw_s | ote_s))
    else $error("warning pin wrong");

  // Error in RUN latches and stops switching
  err_latch_a : assert property (@(posedge clk_i) disable iff (rst_i)
    state == psp_pkg::PSP_RUN && rstn_s && any_err |=> err_latch ##0 hiz_o)
    else $error("error not latched");

  // Latch stays set until reset falls
  latch_hold_a : assert property (@(posedge clk_i) disable iff (rst_i)
    err_latch && !rst_fall |=> err_latch)
    else $error("latch dropped early");

  // Reset fall clears the latch
  latch_clear_a : assert property (@(posedge clk_i) disable iff (rst_i)
    rst_fall |=> !err_latch)
    else $error("latch not cleared on reset fall");

  // Overtemperature error gives both pins low
  ote_code_a : assert property (@(posedge clk_i) disable iff (rst_i)
    rstn_s && ote_s && !rst_fall |=> temp_warning_n_oe_o && fault_indicator_n_oe_o)
    else $error("overtemperature code wrong");

  // Each side alone latches an error
  oc_side_a : assert property (@(posedge clk_i) disable iff (rst_i)
    rstn_s && !rst_fall && (any_oc_hs ^ any_oc_ls) |=> err_latch)
    else $error("single-side overcurrent missed");
endmodule : psp_ctrl

// File: testbench/psp_modulator.sv
// Model of the modulator and system controller that drive the stage
`timescale 1ns/1ps
module psp_modulator #(
  parameter int HALF_PERIOD = 130, // 384.6 kHz switching at 100 MHz
  parameter int HOLD        = 300  // Precharge stand-in; spans a full PWM period first
) (
  input  wire logic       clk_i,     // System clock
  input  wire logic       rst_i,     // Bench reset
  input  wire logic       enable_i,  // Power-up request from the bench
  output logic [1:0]      pwm_o,     // Positive PWM per channel
  output logic            reset_n_o  // Stage reset, active low
);
  logic [7:0]  phase;
  logic [15:0] wait_cnt;
  logic        running;
  // PWM toggles while running; idles low like a pulled-down node
  always_ff @(posedge clk_i) begin
    if (rst_i || !running) begin
      phase <= 8'h00;
      pwm_o <= 2'h0;
    end else if (phase == 8'(HALF_PERIOD - 1)) begin
      phase <= 8'h00;
      pwm_o <= ~pwm_o;
    end else begin
      phase <= phase + 8'h01;
    end
  end
  // Reset waits for precharge and running PWM; falls first at power-down
  always_ff @(posedge clk_i) begin
    if (rst_i || !enable_i) begin
      reset_n_o <= 1'b0;
      wait_cnt  <= 16'h0000;
    end else if (wait_cnt != 16'(HOLD)) begin
      wait_cnt <= wait_cnt + 16'h0001;
    end else begin
      reset_n_o <= running;
    end
  end
  // PWM outlives reset by two cycles so the stage never sees it stop first
  always_ff @(posedge clk_i) begin
    running <= !rst_i && (enable_i || reset_n_o);
  end
endmodule : psp_modulator

// File: testbench/power_stage_protection_control_test.sv
// Self-checking bench for the power stage protection controller
`timescale 1ns/1ps
module power_stage_protection_control_test;
  logic        clk, rst, en, uv, temp_warning_n, overtemp_error, reset_n, cyc, stb, we, ack, irq;
  logic        hiz, flt_d, flt_oe, tw_d, tw_oe;
  logic [1:0]  pwm, oc_hs, oc_ls, hs_on, ls_on;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, q;
  int          fail_count, n_checks;
  // Open-drain pins with their pull-ups
  wire fault_pin = flt_oe ? flt_d : 1'b1;
  wire warn_pin  = tw_oe ? tw_d : 1'b1;

  psp_modulator MOD (.clk_i(clk), .rst_i(rst), .enable_i(en), .pwm_o(pwm),
                     .reset_n_o(reset_n));
  psp_ctrl DUT (.clk_i(clk), .rst_i(rst), .reset_n_i(reset_n), .pwm_positive_input_i(pwm),
    .oc_hs_i(oc_hs), .oc_ls_i(oc_ls), .undervoltage_fault_i(uv), .overtemp_warn_i(temp_warning_n),
    .overtemp_error_i(overtemp_error), .hs_on_o(hs_on), .ls_on_o(ls_on), .hiz_o(hiz),
    .fault_indicator_n_o(flt_d), .fault_indicator_n_oe_o(flt_oe), .temp_warning_n_o(tw_d),
    .temp_warning_n_oe_o(tw_oe), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF),
    .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack),
    .irq_o(irq));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish

  // One classic cycle; holds everything until ack is sampled
  task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                         output logic [31:0] r);
    int n;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    r = rdat;
    check("bus ack", ack, 1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk);
  endtask : wb_xfer

  // Bounded wait for switching to resume, then the normal-state outputs
  task automatic wait_run();
    for (int n = 0; n < 600 && hiz !== 1'b0; n++) @(posedge clk);
    repeat (2) @(posedge clk);
    check("running hiz", hiz, 0);
    check("gates complementary", hs_on ^ ls_on, 2'b11);
    check("normal pins", {warn_pin, fault_pin}, 2'b11);
  endtask : wait_run

  task automatic power_cycle();
    @(posedge clk) en <= 1'b0;
    repeat (6) @(posedge clk);
    check("fault pin in reset", fault_pin, 1);
    check("stage off in reset", {hiz, hs_on, ls_on}, 5'h10);
    @(posedge clk) en <= 1'b1;
    wait_run();
  endtask : power_cycle

  // Error source vector {ote, uv, oc_ls, oc_hs}
  task automatic trip(input logic [5:0] src);
    @(posedge clk) {overtemp_error, uv, oc_ls, oc_hs} <= src;
    repeat (5) @(posedge clk);
    check("stage off on error", {hiz, hs_on, ls_on}, 5'h10);
    check("error pins", {warn_pin, fault_pin}, {~src[5], 1'b0});
    @(posedge clk) {overtemp_error, uv, oc_ls, oc_hs} <= 6'h00;
    repeat (8) @(posedge clk);
    check("error held", {hiz, fault_pin}, 2'b10);
    power_cycle();
  endtask : trip

  task automatic warn_only();
    @(posedge clk) temp_warning_n <= 1'b1;
    repeat (5) @(posedge clk);
    check("warning pins", {warn_pin, fault_pin, hiz}, 3'b010);
    @(posedge clk) temp_warning_n <= 1'b0;
    repeat (5) @(posedge clk);
    check("warning gone", {warn_pin, fault_pin, hiz}, 3'b110);
  endtask : warn_only

  // Software mute forces Hi-Z in RUN without a fault report, then lifts again
  task automatic mute_case();
    wb_xfer(1'b1, psp_pkg::ADDR_CTRL, 32'h00000001, q);
    repeat (2) @(posedge clk);
    check("muted stage", {hiz, hs_on, ls_on, fault_pin}, 6'h21);
    wb_xfer(1'b0, psp_pkg::ADDR_CTRL, 32'h00000000, q);
    check("mute readback", q, 32'h00000001);
    wb_xfer(1'b1, psp_pkg::ADDR_CTRL, 32'h00000000, q);
    repeat (2) @(posedge clk);
    check("unmuted hiz", hiz, 0);
    check("unmuted gates", hs_on ^ ls_on, 2'b11);
  endtask : mute_case

  // Masked, raised, read back and cleared interrupt; unmapped access
  task automatic irq_case();
    check("irq masked", irq, 0);
    wb_xfer(1'b0, psp_pkg::ADDR_IRQ_ST, 32'h00000000, q);
    check("events pending", q, 32'h00000007);
    wb_xfer(1'b1, psp_pkg::ADDR_IRQ_CL, 32'h00000007, q);
    wb_xfer(1'b0, psp_pkg::ADDR_IRQ_ST, 32'h00000000, q);
    check("events cleared", q, 32'h00000000);
    wb_xfer(1'b1, psp_pkg::ADDR_IRQ_EN, 32'h00000001, q);
    wb_xfer(1'b0, psp_pkg::ADDR_IRQ_EN, 32'h00000000, q);
    check("irq enable", q, 32'h00000001);
    @(posedge clk) oc_hs <= 2'b10;
    repeat (6) @(posedge clk);
    check("irq raised", irq, 1);
    wb_xfer(1'b0, psp_pkg::ADDR_STATUS, 32'h00000000, q);
    check("status", q[7:0], 8'hC3);
    @(posedge clk) oc_hs <= 2'b00;
    wb_xfer(1'b1, psp_pkg::ADDR_IRQ_CL, 32'h00000001, q);
    repeat (3) @(posedge clk);
    check("irq cleared", irq, 0);
    wb_xfer(1'b0, 8'hFC, 32'h00000000, q);
    check("unmapped read", q, 32'h00000000);
    power_cycle();
    wb_xfer(1'b0, psp_pkg::ADDR_IRQ_ST, 32'h00000000, q);
    check("reset release event", q, 32'h00000004);
    check("irq stays masked", irq, 0);
  endtask : irq_case

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #100000ns;
    fail_count++;
    tally_and_finish();
  end

  initial begin
    fail_count = 0;
    n_checks = 0;
    {rst, en, uv, temp_warning_n, overtemp_error, cyc, stb, we} = 8'h80;
    {oc_hs, oc_ls, adr, wdat} = '0;
    repeat (10) @(posedge clk);
    check("stage off at reset", {hiz, hs_on, ls_on, fault_pin}, 6'h21);
    rst <= 1'b0;
    @(posedge clk) en <= 1'b1;
    wait_run();
    warn_only();
    mute_case();
    for (int i = 0; i < 6; i++) trip(6'h01 << i);
    irq_case();
    tally_and_finish();
  end
endmodule : power_stage_protection_control_test
